// ---- core/ltd_loop_dial.sv ----
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE1 - Local loop returns own transmit, lights indicator
// RULE2 - Remote loop from switch, gated lead, software
// RULE3 - Far-requested remote loop retransmits received line data
// RULE4 - Sealing current reversal loops line, lights indicator
// RULE5 - Office loop signal returns data, lights indicator
// RULE6 - Send 511 pattern, pulse error per bit
// RULE7 - Error variant corrupts pattern about once per second
// RULE8 - Error variant only from switch, never software
// RULE9 - Store up to 12 digits on return
// RULE10 - Stored number dials on terminal-ready rise
// RULE11 - Empty store clears number, disables auto dial
// RULE12 - Stored number readable without change
// RULE13 - Dial new: report start, echo digits
// RULE14 - No wink within 5 s fails
// RULE15 - Wink under 120 ms short, over 320 long
// RULE16 - No answer in 30 s: no carrier
// RULE17 - Answer gives connect result
// RULE18 - Dial without terminal-ready refused
// RULE19 - Dial while connected refused as off-hook
// RULE20 - Commands ignored until dial result issued
// RULE21 - Hang-up releases line, ends call
// RULE22 - Configurer enables assurance and forced send
// RULE23 - Timers run from millisecond tick
// RULE24 - One loop at once, office loops first
module ltd_loop_dial #(
    parameter int TICK_CYCLES    = ltd_pkg::TICK_CYCLES,
    parameter int WINK_WAIT_MS   = ltd_pkg::WINK_WAIT_MS,
    parameter int ANSWER_WAIT_MS = ltd_pkg::ANSWER_WAIT_MS,
    parameter int INJECT_MS      = ltd_pkg::INJECT_PERIOD_MS,
    parameter int MAX_DIGITS     = ltd_pkg::MAX_DIGITS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sw_local,
    input  wire logic        sw_remote,
    input  wire logic        sw_prbs,
    input  wire logic        sw_prbs_err,
    input  wire logic        dte_local_loop,
    input  wire logic        dte_remote_loop,
    input  wire logic        dte_ready,
    input  wire logic        bit_stb,
    input  wire logic        term_tx_bit,
    input  wire logic        line_rx_bit,
    output logic             line_tx_bit,
    output logic             term_rx_bit,
    input  wire logic        sealing_reversed,
    input  wire logic        co_loop_signal,
    input  wire logic        far_rdl_request,
    output logic             rdl_request,
    output logic             test_mode_indicator,
    output logic             error_pulse,
    input  wire logic        wink_in,
    input  wire logic        answer_in,
    output logic             off_hook,
    output logic      [3:0]  dial_digit,
    output logic             dial_digit_stb
);

    // ****
    // Working widths
    // ****
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
    localparam logic [15:0] T_WINK_WAIT = 16'(WINK_WAIT_MS - 1);
    localparam logic [15:0] T_WINK_MIN  = 16'(ltd_pkg::WINK_MIN_MS);
    localparam logic [15:0] T_WINK_MAX  = 16'(ltd_pkg::WINK_MAX_MS);
    localparam logic [15:0] T_ANSWER    = 16'(ANSWER_WAIT_MS - 1);
    localparam logic [15:0] T_GAP       = 16'(ltd_pkg::DIGIT_GAP_MS - 1);
    localparam logic [15:0] T_INJECT    = 16'(INJECT_MS - 1);
    localparam logic [3:0]  N_DIGITS    = 4'(MAX_DIGITS);

    // ****
    // Millisecond tick
    // ****
    logic [TW-1:0] tick_cnt_ff;
    wire           ms_tick = (tick_cnt_ff == TICK_LAST);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_cnt_ff <= '0;
        else
            tick_cnt_ff <= ms_tick ? '0 : tick_cnt_ff + 1'b1; // RULE23
    end

    // ****
    // Bus decode
    // ****
    ltd_pkg::ltd_ctrl_t ctrl_ff;
    wire acc      = psel & penable;
    wire wr_en    = acc & pwrite;
    wire hit_ctrl = (paddr == ltd_pkg::ADDR_CTRL);
    wire hit_stat = (paddr == ltd_pkg::ADDR_STATUS);
    wire hit_dig  = (paddr == ltd_pkg::ADDR_DIGIT);
    wire hit_cmd  = (paddr == ltd_pkg::ADDR_CMD);
    wire hit_res  = (paddr == ltd_pkg::ADDR_RESULT);
    wire hit_slo  = (paddr == ltd_pkg::ADDR_STORED_LO);
    wire hit_shi  = (paddr == ltd_pkg::ADDR_STORED_HI);
    wire hit_any  = hit_ctrl | hit_stat | hit_dig | hit_cmd | hit_res
                  | hit_slo | hit_shi;

    assign pready  = 1'b1;
    assign pslverr = acc & ~hit_any;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_ff <= ltd_pkg::CTRL_RESET;
        else if (wr_en && hit_ctrl)
            ctrl_ff <= pwdata[3:0];
    end

    // ****
    // Loop arbitration
    // ****
    wire lal_req = ctrl_ff.local_analog_loop | sw_local
                 | (ctrl_ff.dte_loop_en & dte_local_loop);
    wire rdl_req = ctrl_ff.remote_digital_loop | sw_remote
                 | (ctrl_ff.dte_loop_en & dte_remote_loop); // RULE2

    // Office loops win; far, local and remote loop requests are masked by them
    ltd_pkg::ltd_loop_t loop_sel;
    assign loop_sel = sealing_reversed ? ltd_pkg::LOOP_SEAL :   // RULE24
                      co_loop_signal   ? ltd_pkg::LOOP_DSU  :
                      far_rdl_request  ? ltd_pkg::LOOP_FAR  :
                      lal_req          ? ltd_pkg::LOOP_LAL  :
                      rdl_req          ? ltd_pkg::LOOP_RDL  :
                                         ltd_pkg::LOOP_NONE;

    wire loop_to_line = (loop_sel == ltd_pkg::LOOP_SEAL)       // RULE4
                      | (loop_sel == ltd_pkg::LOOP_DSU)        // RULE5
                      | (loop_sel == ltd_pkg::LOOP_FAR);       // RULE3
    wire lal_on       = (loop_sel == ltd_pkg::LOOP_LAL);
    wire rdl_on       = (loop_sel == ltd_pkg::LOOP_RDL);

    // ****
    // Pattern
    // ****
    wire prbs_on = sw_prbs | sw_prbs_err | ctrl_ff.prbs;       // RULE8
    wire inj_on  = sw_prbs_err;                                // RULE8

    logic [8:0]  gen_ff;
    logic [8:0]  chk_ff;
    logic [3:0]  fill_ff;
    logic [15:0] inj_cnt_ff;
    logic        inj_pend_ff;

    wire gen_bit   = gen_ff[8] ^ gen_ff[ltd_pkg::PRBS_TAP];    // RULE6
    wire tx_prbs   = gen_bit ^ (inj_on & inj_pend_ff);         // RULE7
    wire nxt_line_tx = loop_to_line ? line_rx_bit :
                       prbs_on      ? tx_prbs     : term_tx_bit;
    wire rx_path   = lal_on ? nxt_line_tx : line_rx_bit;       // RULE1
    wire chk_exp   = chk_ff[8] ^ chk_ff[ltd_pkg::PRBS_TAP];
    wire chk_sync  = (fill_ff == 4'(ltd_pkg::PRBS_LEN));
    wire inj_due   = ms_tick & (inj_cnt_ff == T_INJECT);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gen_ff  <= ltd_pkg::PRBS_SEED;
            chk_ff  <= '0;
            fill_ff <= '0;
        end
        else if (bit_stb)
        begin
            gen_ff  <= {gen_ff[7:0], gen_bit};
            chk_ff  <= {chk_ff[7:0], rx_path};
            fill_ff <= (!prbs_on) ? 4'h0 : chk_sync ? fill_ff
                                         : fill_ff + 4'h1;
        end
    end

    // Ms-spaced injection, rate independent of line rate
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            inj_cnt_ff  <= '0;
            inj_pend_ff <= 1'b0;
        end
        else
        begin
            if (!inj_on)
                inj_cnt_ff <= '0;
            else if (ms_tick)
                inj_cnt_ff <= inj_due ? 16'h0000 : inj_cnt_ff + 16'h0001;
            if (inj_on && inj_due)
                inj_pend_ff <= 1'b1;                           // RULE7
            else if (bit_stb || !inj_on)
                inj_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            line_tx_bit         <= 1'b1;
            term_rx_bit         <= 1'b1;
            error_pulse         <= 1'b0;
            rdl_request         <= 1'b0;
            test_mode_indicator <= 1'b0;
        end
        else
        begin
            if (bit_stb)
            begin
                line_tx_bit <= nxt_line_tx;
                term_rx_bit <= rx_path;
            end
            error_pulse <= bit_stb & prbs_on & chk_sync
                         & (rx_path != chk_exp);               // RULE6
            rdl_request <= rdl_on;
            test_mode_indicator <= (loop_sel != ltd_pkg::LOOP_NONE)
                                 | prbs_on;                    // RULE1
        end
    end

    // ****
    // Number storage
    // ****
    ltd_pkg::ltd_state_t state_ff;
    ltd_pkg::ltd_state_t nxt_state;
    logic [3:0]  entry_ff  [MAX_DIGITS];
    logic [3:0]  stored_ff [MAX_DIGITS];
    logic [3:0]  dial_ff   [MAX_DIGITS];
    logic [3:0]  entry_cnt_ff;
    logic [3:0]  stored_cnt_ff;
    logic [3:0]  dial_cnt_ff;
    logic [3:0]  dial_idx_ff;
    logic        stored_ok_ff;
    logic        dte_ready_ff;
    logic [15:0] timer_ff;
    logic        start;
    logic        evt;
    ltd_pkg::ltd_result_t evt_code;
    ltd_pkg::ltd_result_t result_ff;
    logic        result_new_ff;
    logic [3:0]  echo_ff;

    // Commands are dropped while an attempt is unresolved
    wire busy     = (state_ff != ltd_pkg::ST_IDLE)
                  & (state_ff != ltd_pkg::ST_CONN);            // RULE20
    wire cmd_wr   = wr_en & hit_cmd & ~busy;
    wire cmd_st   = cmd_wr & (pwdata[1:0] == ltd_pkg::CMD_STORE);
    wire cmd_dial = cmd_wr & (pwdata[1:0] == ltd_pkg::CMD_DIAL);
    wire cmd_hang = cmd_wr & (pwdata[1:0] == ltd_pkg::CMD_HANGUP);
    wire dig_ok   = wr_en & hit_dig & ~busy & (entry_cnt_ff < N_DIGITS)
                  & (pwdata[3:0] <= ltd_pkg::DIGIT_MAX);       // RULE9
    wire auto_dial = dte_ready & ~dte_ready_ff & stored_ok_ff
                   & ~cmd_wr;                                  // RULE10
    wire last_sent = (dial_idx_ff == dial_cnt_ff);

    always_ff @(posedge pclk)
    begin
        if (dig_ok)
            entry_ff[entry_cnt_ff] <= pwdata[3:0];
        if (cmd_st)
            stored_ff <= entry_ff;                             // RULE9
        if (start)
            dial_ff <= cmd_dial ? entry_ff : stored_ff;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            entry_cnt_ff  <= '0;
            stored_cnt_ff <= '0;
            stored_ok_ff  <= 1'b0;
            dte_ready_ff  <= 1'b0;
        end
        else
        begin
            dte_ready_ff <= dte_ready;
            if (cmd_st || cmd_dial)
                entry_cnt_ff <= '0;
            else if (dig_ok)
                entry_cnt_ff <= entry_cnt_ff + 4'h1;
            if (cmd_st)
            begin
                stored_cnt_ff <= entry_cnt_ff;
                stored_ok_ff  <= (entry_cnt_ff != 4'h0);       // RULE11
            end
        end
    end

    // ****
    // Dial sequencer
    // ****
    always_comb
    begin
        nxt_state = state_ff;
        start     = 1'b0;
        evt       = 1'b0;
        evt_code  = ltd_pkg::RES_NONE;
        case (state_ff)
            ltd_pkg::ST_IDLE:
            begin
                if (cmd_dial && !dte_ready)
                begin
                    evt      = 1'b1;                           // RULE18
                    evt_code = ltd_pkg::RES_DTR_OFF;
                end
                else if (cmd_dial || auto_dial)
                begin
                    nxt_state = ltd_pkg::ST_SEIZE;
                    start     = 1'b1;
                    evt       = 1'b1;                          // RULE13
                    evt_code  = ltd_pkg::RES_DIALING;
                end
            end
            ltd_pkg::ST_SEIZE:
            begin
                if (wink_in)
                    nxt_state = ltd_pkg::ST_WINK;
                else if (ms_tick && timer_ff >= T_WINK_WAIT)
                begin
                    nxt_state = ltd_pkg::ST_IDLE;              // RULE14
                    evt       = 1'b1;
                    evt_code  = ltd_pkg::RES_NO_WINK;
                end
            end
            ltd_pkg::ST_WINK:
            begin
                if (!wink_in && timer_ff < T_WINK_MIN)
                begin
                    nxt_state = ltd_pkg::ST_IDLE;              // RULE15
                    evt       = 1'b1;
                    evt_code  = ltd_pkg::RES_SHORT_WINK;
                end
                else if (!wink_in)
                    nxt_state = ltd_pkg::ST_SEND;
                else if (ms_tick && timer_ff >= T_WINK_MAX)
                begin
                    nxt_state = ltd_pkg::ST_IDLE;              // RULE15
                    evt       = 1'b1;
                    evt_code  = ltd_pkg::RES_LONG_WINK;
                end
            end
            ltd_pkg::ST_SEND:
            begin
                if (ms_tick && timer_ff >= T_GAP && last_sent)
                    nxt_state = ltd_pkg::ST_WAIT;
            end
            ltd_pkg::ST_WAIT:
            begin
                if (answer_in)
                begin
                    nxt_state = ltd_pkg::ST_CONN;              // RULE17
                    evt       = 1'b1;
                    evt_code  = ltd_pkg::RES_CONNECT;
                end
                else if (ms_tick && timer_ff >= T_ANSWER)
                begin
                    nxt_state = ltd_pkg::ST_IDLE;              // RULE16
                    evt       = 1'b1;
                    evt_code  = ltd_pkg::RES_NO_CARRIER;
                end
            end
            ltd_pkg::ST_CONN:
            begin
                if (cmd_hang)
                    nxt_state = ltd_pkg::ST_IDLE;              // RULE21
                else if (cmd_dial)
                begin
                    evt      = 1'b1;                           // RULE19
                    evt_code = ltd_pkg::RES_OFF_HOOK;
                end
            end
            default:
                nxt_state = ltd_pkg::ST_IDLE;
        endcase
    end

    wire send_now = (state_ff == ltd_pkg::ST_SEND) & ms_tick
                  & (timer_ff >= T_GAP) & ~last_sent;          // RULE13
    wire tmr_clr  = (nxt_state != state_ff) | send_now;
    wire rd_res   = acc & ~pwrite & hit_res;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff       <= ltd_pkg::ST_IDLE;
            timer_ff       <= '0;
            dial_cnt_ff    <= '0;
            dial_idx_ff    <= '0;
            off_hook       <= 1'b0;
            dial_digit     <= '0;
            dial_digit_stb <= 1'b0;
            echo_ff        <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (tmr_clr)
                timer_ff <= '0;
            else if (ms_tick)
                timer_ff <= timer_ff + 16'h0001;               // RULE23
            if (start)
            begin
                dial_cnt_ff <= cmd_dial ? entry_cnt_ff : stored_cnt_ff;
                dial_idx_ff <= '0;
            end
            else if (send_now)
                dial_idx_ff <= dial_idx_ff + 4'h1;
            off_hook       <= (nxt_state != ltd_pkg::ST_IDLE); // RULE21
            dial_digit_stb <= send_now;
            if (send_now)
            begin
                dial_digit <= dial_ff[dial_idx_ff];
                echo_ff    <= dial_ff[dial_idx_ff];            // RULE13
            end
        end
    end

    // New event beats the clearing read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result_ff     <= ltd_pkg::RES_NONE;
            result_new_ff <= 1'b0;
        end
        else if (evt)
        begin
            result_ff     <= evt_code;
            result_new_ff <= 1'b1;
        end
        else if (rd_res)
            result_new_ff <= 1'b0;
    end

    // ****
    // Read data
    // ****
    logic [47:0] stored_flat;
    genvar gi;
    generate
        for (gi = 0; gi < 12; gi++)
        begin : g_pack
            if (gi < MAX_DIGITS)
            begin : g_dig
                assign stored_flat[gi*4 +: 4] = stored_ff[gi]; // RULE12
            end
            else
            begin : g_pad
                assign stored_flat[gi*4 +: 4] = 4'h0;
            end
        end
    endgenerate

    wire [31:0] stat_word = {19'h0, entry_cnt_ff, stored_ok_ff, busy,
                             off_hook, inj_on, prbs_on, loop_sel,
                             test_mode_indicator};
    wire [31:0] res_word  = {16'h0, dial_idx_ff, echo_ff, 3'h0,
                             result_new_ff, result_ff};
    wire [31:0] rd_mux =
        hit_ctrl ? {28'h0, ctrl_ff} :
        hit_stat ? stat_word :
        hit_res  ? res_word :
        hit_slo  ? stored_flat[31:0] :
        hit_shi  ? {12'h0, stored_cnt_ff, stored_flat[47:32]} :
                   32'h0000_0000;

    // Setup capture keeps access zero-wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (psel && !penable && !pwrite)
            prdata <= rd_mux;
    end

endmodule // ltd_loop_dial
`default_nettype wire

// ---- core/ltd_pkg.sv ----
`default_nettype none
package ltd_pkg;

    // ****
    // Timing
    // ****
    localparam int TICK_CYCLES      = 10_000;
    localparam int WINK_WAIT_MS     = 5000;
    localparam int WINK_MIN_MS      = 120;
    localparam int WINK_MAX_MS      = 320;
    localparam int ANSWER_WAIT_MS   = 30000;
    localparam int INJECT_PERIOD_MS = 1000;
    localparam int DIGIT_GAP_MS     = 100;

    // ****
    // Sizes
    // ****
    localparam int MAX_DIGITS = 12;
    localparam int PRBS_LEN   = 9;
    localparam int PRBS_TAP   = 4;
    localparam logic [8:0] PRBS_SEED = 9'h1FF;

    // ****
    // Register map
    // ****
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_DIGIT     = 8'h08;
    localparam logic [7:0] ADDR_CMD       = 8'h0C;
    localparam logic [7:0] ADDR_RESULT    = 8'h10;
    localparam logic [7:0] ADDR_STORED_LO = 8'h14;
    localparam logic [7:0] ADDR_STORED_HI = 8'h18;
    localparam logic [3:0] CTRL_RESET     = 4'h0;
    localparam logic [3:0] DIGIT_MAX      = 4'h9;

    localparam logic [1:0] CMD_STORE  = 2'h0;
    localparam logic [1:0] CMD_DIAL   = 2'h1;
    localparam logic [1:0] CMD_HANGUP = 2'h2;

    typedef struct packed {
        logic dte_loop_en;
        logic prbs;
        logic remote_digital_loop;
        logic local_analog_loop;
    } ltd_ctrl_t;

    typedef enum logic [3:0] {
        RES_NONE       = 4'h0,
        RES_DIALING    = 4'h1,
        RES_CONNECT    = 4'h2,
        RES_NO_WINK    = 4'h3,
        RES_SHORT_WINK = 4'h4,
        RES_LONG_WINK  = 4'h5,
        RES_NO_CARRIER = 4'h6,
        RES_DTR_OFF    = 4'h7,
        RES_OFF_HOOK   = 4'h8
    } ltd_result_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SEIZE = 3'b001,
        ST_WINK  = 3'b011,
        ST_SEND  = 3'b010,
        ST_WAIT  = 3'b110,
        ST_CONN  = 3'b111
    } ltd_state_t;

    typedef enum logic [2:0] {
        LOOP_NONE = 3'h0,
        LOOP_SEAL = 3'h1,
        LOOP_DSU  = 3'h2,
        LOOP_FAR  = 3'h3,
        LOOP_LAL  = 3'h4,
        LOOP_RDL  = 3'h5
    } ltd_loop_t;

endpackage
`default_nettype wire

// ---- bench/ltd_co_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// Office side: wink after seizure, then answer
// ****
module ltd_co_model #(
    parameter int TICK = 10
) (
    input  wire logic       pclk,
    input  wire logic       off_hook,
    input  wire logic [9:0] wink_ms,
    input  wire logic       ans_en,
    output logic            wink_in,
    output logic            answer_in
);
    int cnt = 0;
    // Answer is a level, dropped when the line is released or ans_en goes low
    always @(posedge pclk)
    begin
        cnt <= off_hook ? cnt + 1 : 0;
        wink_in <= off_hook && wink_ms != '0 && cnt >= 20
                   && cnt < 20 + int'(wink_ms) * TICK;
        answer_in <= off_hook && ans_en && cnt > 120 + int'(wink_ms) * TICK;
    end
endmodule // ltd_co_model
`default_nettype wire

// ---- bench/ltd_loop_dial_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module ltd_loop_dial_chk (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       sw_local,
    input wire logic       bit_stb,
    input wire logic       line_rx_bit,
    input wire logic       line_tx_bit,
    input wire logic       sealing_reversed,
    input wire logic       co_loop_signal,
    input wire logic       far_rdl_request,
    input wire logic       test_mode_indicator,
    input wire logic       error_pulse,
    input wire logic       off_hook,
    input wire logic [3:0] dial_digit,
    input wire logic       dial_digit_stb
);
    // ****
    // Loops, pattern and dialling
    // ****
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Request held three edges so the loop select has settled
    sequence echo;
        ##1 line_tx_bit == $past(line_rx_bit);
    endsequence
    chk_local_tm: assert property
        ($rose(sw_local) |-> ##[1:3] test_mode_indicator) else $error("tm");
    chk_seal_tm: assert property
        ($rose(sealing_reversed) |-> ##[1:3] test_mode_indicator)
        else $error("tm");
    chk_office_tm: assert property
        ($rose(co_loop_signal) |-> ##[1:3] test_mode_indicator)
        else $error("tm");
    chk_seal_echo: assert property
        (sealing_reversed && $past(sealing_reversed, 3) && bit_stb |-> echo)
        else $error("seal echo");
    chk_office_echo: assert property
        (co_loop_signal && $past(co_loop_signal, 3) && !sealing_reversed
        && bit_stb |-> echo) else $error("office echo");
    chk_far_echo: assert property
        (far_rdl_request && $past(far_rdl_request, 3) && !co_loop_signal
        && !sealing_reversed && bit_stb |-> echo) else $error("far echo");
    chk_err_bit: assert property
        (error_pulse |-> $past(bit_stb)) else $error("error pulse");
    chk_digit_line: assert property
        (dial_digit_stb |-> off_hook && dial_digit <= 4'h9) else $error("dg");
endmodule // ltd_loop_dial_chk
`default_nettype wire

// ---- bench/ltd_loop_dial_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module ltd_loop_dial_bench;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = '0, k = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic        pready, pslverr, perr, line_tx_bit, term_rx_bit, rdl_request;
    logic        test_mode_indicator, error_pulse, off_hook, dial_digit_stb;
    logic [3:0]  dial_digit;
    logic        sw_local = 0, sw_remote = 0, sw_prbs = 0, sw_prbs_err = 0;
    logic        dte_local_loop = 0, dte_remote_loop = 0, dte_ready = 0;
    logic        bit_stb = 0, term_tx_bit = 0, line_rx_bit = 0, lb = 0;
    logic        sealing_reversed = 0, co_loop_signal = 0, far_rdl_request = 0;
    logic        wink_in, answer_in, ans_en = 0, inj = 0;
    logic [9:0]  wink_ms = '0;
    int          fails = 0, cmp_count = 0, errs = 0;
    // ****
    // Short timers keep the run brief
    // ****
    ltd_loop_dial #(.TICK_CYCLES(10), .WINK_WAIT_MS(20), .ANSWER_WAIT_MS(40),
                    .INJECT_MS(8)) dut (.*);
    ltd_co_model #(.TICK(10)) co (.*);
    initial
        forever #50 pclk = ~pclk;
    always @(posedge pclk)
    begin
        k <= k + 8'h01;
        bit_stb <= k[1:0] == 2'h0;
        errs <= errs + int'(error_pulse);
        if (k[1:0] == 2'h2)
            {term_tx_bit, line_rx_bit} <=
                {k[4], lb ? line_tx_bit ^ inj : k[5] ^ k[3]};
    end
    task automatic finish_test;
        if (fails == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        cmp_count++;
        fails += int'(s !== e);
        if (s !== e)
            $display("unexpected %s expected %h seen %h", n, e, s);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        {r, perr} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    task automatic cmd(input logic [31:0] d);
        apb(1'h1, ltd_pkg::ADDR_CMD, d);
    endtask
    task automatic res(input logic [3:0] e);
        r = '0;
        for (int i = 0; i < 6000 && !(r[4] && r[3:0] != 4'h1); i++)
            apb(1'h0, ltd_pkg::ADDR_RESULT, '0);
        chk("result", r[3:0], e);
    endtask
    task automatic t_loops;
        sw_local <= 1'h1;
        idle(40);
        repeat (8) @(posedge pclk iff k[3:0] == 4'hE)
            chk("echo", term_rx_bit, term_tx_bit);
        co_loop_signal <= 1'h1;
        idle(40);
        {co_loop_signal, sealing_reversed} <= 2'h1;
        idle(40);
        {sealing_reversed, sw_local, far_rdl_request} <= 3'h1;
        idle(40);
        far_rdl_request <= 1'h0;
        idle(40);
        chk("indicator", test_mode_indicator, 1'h0);
    endtask
    task automatic t_remote;
        sw_remote <= 1'h1;
        idle(5);
        chk("remote", rdl_request, 1'h1);
        {sw_remote, dte_remote_loop} <= 2'h1;
        idle(5);
        chk("lead gated", rdl_request, 1'h0);
        apb(1'h1, ltd_pkg::ADDR_CTRL, 32'h8);
        idle(5);
        chk("lead", rdl_request, 1'h1);
        dte_remote_loop <= 1'h0;
        apb(1'h1, ltd_pkg::ADDR_CTRL, 32'h2);
        idle(5);
        chk("software", rdl_request, 1'h1);
        apb(1'h0, 8'h40, '0);
        chk("slverr", perr, 1'h1);
    endtask
    task automatic t_prbs;
        int e;
        lb <= 1'h1;
        apb(1'h1, ltd_pkg::ADDR_CTRL, 32'h4);
        apb(1'h0, ltd_pkg::ADDR_STATUS, '0);
        chk("pattern", r[5:4], 2'h1);
        idle(100);
        e = errs;
        idle(200);
        chk("clean", 32'(errs - e), '0);
        inj <= 1'h1;
        idle(4);
        inj <= 1'h0;
        idle(40);
        chk("flagged", errs != e, 1'h1);
        apb(1'h1, ltd_pkg::ADDR_CTRL, '0);
        sw_prbs_err <= 1'h1;
        idle(100);
        e = errs;
        idle(400);
        chk("injected", errs - e >= 3, 1'h1);
        {sw_prbs_err, lb} <= 2'h0;
    endtask
    task automatic t_dial;
        for (int i = 0; i < 13; i++)
            apb(1'h1, ltd_pkg::ADDR_DIGIT, 32'(i % 10));
        cmd(32'h0);
        apb(1'h0, ltd_pkg::ADDR_STORED_LO, '0);
        chk("stored lo", r, 32'h76543210);
        apb(1'h0, ltd_pkg::ADDR_STORED_HI, '0);
        chk("stored hi", r[19:0], 20'hC1098);
        apb(1'h1, ltd_pkg::ADDR_DIGIT, 32'h5);
        cmd(32'h1);
        res(4'h7);
        {wink_ms, ans_en, dte_ready} <= {10'h0C8, 2'h3};
        idle(5);
        cmd(32'h0);
        res(4'h2);
        chk("sent", r[15:8], 8'hC1);
        apb(1'h0, ltd_pkg::ADDR_STORED_HI, '0);
        chk("kept", r[19:16], 4'hC);
        cmd(32'h1);
        res(4'h8);
        cmd(32'h2);
        idle(3);
        chk("hung up", off_hook, 1'h0);
    endtask
    task automatic t_faults;
        logic [14:0] ft [4] = '{15'h0644, 15'h3205, 15'h0003, 15'h1906};
        for (int i = 0; i < 4; i++)
        begin
            {wink_ms, ans_en} <= ft[i][14:4];
            apb(1'h1, ltd_pkg::ADDR_DIGIT, 32'h7);
            cmd(32'h1);
            res(ft[i][3:0]);
            idle(3);
            chk("released", off_hook, 1'h0);
        end
        cmd(32'h0);
        apb(1'h0, ltd_pkg::ADDR_STORED_HI, '0);
        chk("cleared", r[19:16], 4'h0);
        dte_ready <= 1'h0;
        idle(2);
        dte_ready <= 1'h1;
        idle(50);
        chk("no auto dial", off_hook, 1'h0);
    endtask
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        t_loops;
        t_remote;
        t_prbs;
        t_dial;
        t_faults;
        finish_test;
    end
    initial
    begin
        idle(90000);
        fails++;
        finish_test;
    end
endmodule // ltd_loop_dial_bench
bind ltd_loop_dial ltd_loop_dial_chk u_chk (.pclk, .presetn, .sw_local,
    .bit_stb, .line_rx_bit, .line_tx_bit, .sealing_reversed, .co_loop_signal,
    .far_rdl_request, .test_mode_indicator, .error_pulse, .off_hook,
    .dial_digit, .dial_digit_stb);
`default_nettype wire
